// [rtl/attenuator_serial_control.sv]
// Control logic of a seven-bit step attenuator with serial and parallel
// control. The serial shift register runs on the link clock; everything
// else runs on clk. Pins are expected to be pulled as the board requires.
//
// Contract
// - Serial control is used when the select pin is high, parallel when low.
// - Serial bits go into a sixteen-bit shift register of two bytes.
// - The frame carries the attenuation byte first, then the address byte.
// - Only three address bits are compared with the board address pins.
// - On an address mismatch the attenuation state is kept unchanged.
// - Unconnected board address pins read as zero, giving address 000.
// - Up to eight devices share the bus and each obeys only its address.
// - Code zero is minimum and all ones is maximum attenuation.
// - The code is binary weighted in quarter decibel steps to 31.75 dB.
// - A rising latch strobe moves both bytes into the active register.
// - The shift register holds still while the latch strobe is high.
// - After reset the active state is maximum attenuation, address zero.
`timescale 1ns/1ps
`default_nettype none
module attenuator_serial_control
  import atten_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               serial_clk,
  input  wire logic               serial_data,
  input  wire logic               latch_strobe,
  input  wire logic               interface_select_pin,
  input  wire logic               board_addr_bit0,
  input  wire logic               board_addr_bit1,
  input  wire logic               board_addr_bit2,
  input  wire logic [ATTEN_W-1:0] parallel_word,
  output logic      [ATTEN_W-1:0] atten_code,
  output logic      [WORD_W-1:0]  active_addr_word,
  output logic                    serial_mode
);

  // Link domain: the shift register.
  logic [SHIFT_W-1:0] shift_r;
  logic [SHIFT_W-1:0] shift_nxt;

  // The first bit sent ends up at bit 0 after sixteen shifts, so the
  // attenuation byte lands low and the address byte lands high.
  always_comb
  begin
    if (latch_strobe)
      shift_nxt = shift_r;
    else
      shift_nxt = {serial_data, shift_r[SHIFT_W-1:1]};
  end

  always_ff @(posedge serial_clk or negedge rst_n)
  begin
    if (!rst_n)
      shift_r <= SHIFT_RESET;
    else
      shift_r <= shift_nxt;
  end

  // Core domain: synchronised pins.
  pin_bundle_t pins_raw;
  pin_bundle_t pins_s;
  logic [PIN_W-1:0] pins_q;

  always_comb
  begin
    pins_raw.latch      = latch_strobe;
    pins_raw.serial_sel = interface_select_pin;
    pins_raw.board_addr = {board_addr_bit2, board_addr_bit1, board_addr_bit0};
    pins_raw.par_word   = parallel_word;
  end

  sync_2ff #(
    .WIDTH (PIN_W)
  ) u_pin_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (pins_raw),
    .q     (pins_q)
  );

  assign pins_s = pin_bundle_t'(pins_q);

  logic               latch_d_r;
  logic               latch_d_nxt;
  logic [ATTEN_W-1:0] atten_r;
  logic [ATTEN_W-1:0] atten_nxt;
  logic [WORD_W-1:0]  addr_r;
  logic [WORD_W-1:0]  addr_nxt;
  logic               mode_r;
  logic               mode_nxt;
  logic               latch_rise;
  logic               addr_hit;
  logic [WORD_W-1:0]  rx_atten_byte;
  logic [WORD_W-1:0]  rx_addr_byte;

  logic [SYNC_SETTLE-1:0] settle_r;
  logic [SYNC_SETTLE-1:0] settle_nxt;

  // The shift register is read here only after the strobe has been high
  // for two core cycles, when shifting has stopped and the bits are quiet.
  assign rx_atten_byte = shift_r[ATTEN_LSB +: WORD_W];
  assign rx_addr_byte  = shift_r[ADDR_WORD_LSB +: WORD_W];
  assign latch_rise    = pins_s.latch & ~latch_d_r & settle_r[SYNC_SETTLE-1];
  // Pull-downs on the board make open pins compare as zero.
  assign addr_hit = (rx_addr_byte[BADDR_W-1:0] == pins_s.board_addr);

  always_comb
  begin
    latch_d_nxt = pins_s.latch;
    mode_nxt    = pins_s.serial_sel;
    atten_nxt   = atten_r;
    addr_nxt    = addr_r;
    if (pins_s.serial_sel)
    begin
      if (latch_rise && addr_hit)
      begin
        atten_nxt = rx_atten_byte[ATTEN_W-1:0];
        addr_nxt  = rx_addr_byte;
      end
    end
    else if (pins_s.latch)
    begin
      // Strobe high follows the pins; strobe low holds the last word.
      atten_nxt = pins_s.par_word;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      latch_d_r <= 1'b0;
      mode_r    <= 1'b0;
      atten_r   <= ATTEN_RESET;
      addr_r    <= ADDR_RESET;
    end
    else
    begin
      latch_d_r <= latch_d_nxt;
      mode_r    <= mode_nxt;
      atten_r   <= atten_nxt;
      addr_r    <= addr_nxt;
    end
  end

  // The pin synchroniser resets to zero while the strobe idles high, so its
  // first cycles would look like a rising edge and load a stale frame.
  // Edges are ignored until the strobe history has settled.
  always_comb
  begin
    settle_nxt = {settle_r[SYNC_SETTLE-2:0], 1'b1};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      settle_r <= '0;
    else
      settle_r <= settle_nxt;
  end

  assign atten_code       = atten_r;
  assign active_addr_word = addr_r;
  assign serial_mode      = mode_r;

  // Checks.
  logic touched_r;
  logic touched_nxt;

  always_comb
  begin
    // Only a real load request may move the state away from reset.
    if (pins_s.serial_sel)
      touched_nxt = touched_r | (latch_rise & addr_hit);
    else
      touched_nxt = touched_r | pins_s.latch;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      touched_r <= 1'b0;
    else
      touched_r <= touched_nxt;
  end

  sequence s_serial_latch;
    pins_s.serial_sel && latch_rise;
  endsequence

  sequence s_serial_hit;
    s_serial_latch ##0 addr_hit;
  endsequence

  AST_SHIFT_IN: assert property (@(posedge serial_clk) disable iff (!rst_n)
    !latch_strobe |=> shift_r[SHIFT_W-1] == $past(serial_data)
      && shift_r[SHIFT_W-2:0] == $past(shift_r[SHIFT_W-1:1]))
    else $error("Shift register did not take serial data.");

  AST_SHIFT_HOLD: assert property (@(posedge serial_clk) disable iff (!rst_n)
    latch_strobe |=> $stable(shift_r))
    else $error("Shift register moved with the strobe high.");

  AST_RESET_STATE: assert property (@(posedge clk) disable iff (!rst_n)
    !touched_r |-> atten_r == ATTEN_RESET && addr_r == ADDR_RESET)
    else $error("Active state left reset value without cause.");

  AST_SERIAL_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
    s_serial_hit |=> atten_r == $past(rx_atten_byte[ATTEN_W-1:0])
      && addr_r == $past(rx_addr_byte))
    else $error("Matched serial frame was not loaded.");

  AST_ADDR_MISS: assert property (@(posedge clk) disable iff (!rst_n)
    s_serial_latch ##0 !addr_hit |=> $stable(atten_r) && $stable(addr_r))
    else $error("Mismatched frame changed the attenuation.");

  AST_ADDR_BITS: assert property (@(posedge clk) disable iff (!rst_n)
    s_serial_hit |=> addr_r[BADDR_W-1:0] == $past(pins_s.board_addr))
    else $error("Loaded address bits differ from the board address.");

  AST_SERIAL_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
    pins_s.serial_sel && !latch_rise |=> $stable(atten_r))
    else $error("Serial mode changed state without a strobe edge.");

  AST_PARALLEL: assert property (@(posedge clk) disable iff (!rst_n)
    !pins_s.serial_sel && pins_s.latch |=> atten_r == $past(pins_s.par_word))
    else $error("Parallel word not followed with the strobe high.");

  AST_PARALLEL_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !pins_s.serial_sel && !pins_s.latch |=> $stable(atten_r))
    else $error("Parallel state changed with the strobe low.");

  AST_MODE_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
    interface_select_pin [*4] |-> serial_mode)
    else $error("Mode flag does not follow the select pin.");

endmodule
`default_nettype wire

// [rtl/atten_pkg.sv]
// Constants and carrier types for the step attenuator control logic.
// Assumes a single core clock domain plus the serial link clock.
package atten_pkg;

  localparam int SHIFT_W      = 16;
  localparam int WORD_W       = 8;
  localparam int ATTEN_W      = 7;
  localparam int BADDR_W      = 3;
  // Attenuation word sits in the low byte, address word in the high byte.
  localparam int ATTEN_LSB    = 0;
  localparam int ADDR_WORD_LSB = 8;
  // Reset state: maximum attenuation, address word all zeros.
  localparam logic [ATTEN_W-1:0] ATTEN_RESET = 7'h7F;
  localparam logic [WORD_W-1:0]  ADDR_RESET  = 8'h00;
  localparam logic [SHIFT_W-1:0] SHIFT_RESET = 16'h0000;
  // One code step is a quarter decibel, so 7'h7F is 31.75 dB.
  localparam int QDB_PER_STEP = 1;
  // Core cycles after reset before the synchronised strobe history is valid.
  localparam int SYNC_SETTLE  = 3;

  typedef struct packed {
    logic                 latch;
    logic                 serial_sel;
    logic [BADDR_W-1:0]   board_addr;
    logic [ATTEN_W-1:0]   par_word;
  } pin_bundle_t;

  localparam int PIN_W = $bits(pin_bundle_t);

endpackage

// [rtl/sync_2ff.sv]
// Two flip-flop synchroniser for a bundle of slow level inputs.
// Assumes each bit changes slowly compared with the destination clock.
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] q_r;
  logic [WIDTH-1:0] q_nxt;

  always_comb
  begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q_r    <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
    end
  end

  assign q = q_r;

endmodule
`default_nettype wire

// [sim/serial_ctrl_model.sv]
// Board controller model that drives the three-wire serial bus.
// Assumes the device samples data on the rising serial clock edge.
`timescale 1ns/1ps
`default_nettype none
module serial_ctrl_model (
  output logic sck,
  output logic sdat,
  output logic stb
);
  initial
  begin
    sck  = 1'b0;
    sdat = 1'b0;
    stb  = 1'b1;
  end
  // The clock stands still between bursts; data is inverted once done.
  task automatic clock_bits(input logic [15:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      sdat = b[i];
      #32 sck = 1'b1;
      #32 sck = 1'b0;
    end
    sdat = ~sdat;
  endtask
  task automatic send_frame(input logic [15:0] f);
    stb = 1'b0;
    clock_bits(f, 16);
    #16 stb = 1'b1;
    #100;
  endtask
  task automatic set_strobe(input logic v);
    stb = v;
  endtask
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the attenuator control logic.
// Assumes the serial controller model drives the link pins.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import atten_pkg::*;
  logic               clk;
  logic               rst_n;
  logic               sel;
  logic [2:0]         ba;
  logic [ATTEN_W-1:0] par;
  wire logic          sck;
  wire logic          sdat;
  wire logic          stb;
  logic [ATTEN_W-1:0] code;
  logic [WORD_W-1:0]  aw;
  logic               smode;
  int                 num_errors;
  int                 n_compared;
  serial_ctrl_model ctrl (.sck(sck), .sdat(sdat), .stb(stb));
  attenuator_serial_control attenuator_serial_control_inst (
    .clk(clk), .rst_n(rst_n), .serial_clk(sck), .serial_data(sdat),
    .latch_strobe(stb), .interface_select_pin(sel),
    .board_addr_bit0(ba[0]), .board_addr_bit1(ba[1]),
    .board_addr_bit2(ba[2]), .parallel_word(par), .atten_code(code),
    .active_addr_word(aw), .serial_mode(smode));
  always #2.5 clk = ~clk;
  task automatic chk(input string nm, input logic [7:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic stop_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic expect_state(input logic [6:0] c, input logic [7:0] a);
    chk("atten_code", {1'b0, c}, {1'b0, code});
    chk("active_addr_word", a, aw);
  endtask
  task automatic sac(input logic [15:0] f, input logic [6:0] c,
                     input logic [7:0] a);
    ctrl.send_frame(f);
    wait_clk(2);
    expect_state(c, a);
  endtask
  task automatic test_reset;
    expect_state(7'h7F, 8'h00);
    wait_clk(2);
    rst_n = 1'b1;
    wait_clk(6);
    chk("serial_mode", 8'h01, {7'h00, smode});
    expect_state(7'h7F, 8'h00);
  endtask
  task automatic test_match;
    sac(16'h0001, 7'h01, 8'h00);
    sac(16'h80FF, 7'h7F, 8'h80);
    sac(16'hF8AA, 7'h2A, 8'hF8);
  endtask
  task automatic test_mismatch;
    sac(16'hF955, 7'h2A, 8'hF8);
    ba = 3'b101;
    sac(16'h0D13, 7'h13, 8'h0D);
    sac(16'h0000, 7'h13, 8'h0D);
  endtask
  task automatic test_hold;
    ctrl.clock_bits(16'h0D00, 16);
    ctrl.set_strobe(1'b0);
    #50 ctrl.set_strobe(1'b1);
    wait_clk(8);
    expect_state(7'h13, 8'h0D);
  endtask
  task automatic test_parallel;
    sel = 1'b0;
    par = 7'h55;
    wait_clk(8);
    chk("serial_mode", 8'h00, {7'h00, smode});
    chk("atten_code", 8'h55, {1'b0, code});
    ctrl.set_strobe(1'b0);
    wait_clk(8);
    par = 7'h2A;
    wait_clk(8);
    chk("atten_code", 8'h55, {1'b0, code});
    ctrl.set_strobe(1'b1);
    wait_clk(8);
    chk("atten_code", 8'h2A, {1'b0, code});
    sel = 1'b1;
  endtask
  initial
  begin
    clk        = 1'b0;
    rst_n      = 1'b0;
    sel        = 1'b1;
    ba         = 3'b000;
    par        = 7'h00;
    num_errors = 0;
    n_compared = 0;
    wait_clk(18);
    test_reset();
    test_match();
    test_mismatch();
    test_hold();
    test_parallel();
    stop_test();
  end
  // Cuts a hang short well after the expected run length.
  initial
  begin
    #60000;
    num_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
